// *** grc_pkg.sv ***
package grc_pkg;
   // ------------------------------------------------------------
   // bus commands (byte received with attention true)
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_GTL = 8'h01;
   localparam logic [7:0] CMD_SDC = 8'h04;
   localparam logic [7:0] CMD_GET = 8'h08;
   localparam logic [7:0] CMD_LLO = 8'h11;
   localparam logic [7:0] CMD_DCL = 8'h14;
   localparam logic [7:0] CMD_SPE = 8'h18;
   localparam logic [7:0] CMD_SPD = 8'h19;
   localparam logic [7:0] CMD_UNL = 8'h3F;
   localparam logic [7:0] CMD_UNT = 8'h5F;
   localparam logic [2:0] GRP_LISTEN = 3'h1;
   localparam logic [2:0] GRP_TALK = 3'h2;
   // ------------------------------------------------------------
   // program characters and two-character codes
   // ------------------------------------------------------------
   localparam logic [7:0] CH_LF = 8'h0A;
   localparam logic [7:0] CH_EXCL = 8'h21;
   localparam logic [7:0] CH_PLUS = 8'h2B;
   localparam logic [7:0] CH_MINUS = 8'h2D;
   localparam logic [7:0] CH_DOT = 8'h2E;
   localparam logic [7:0] CH_QUEST = 8'h3F;
   localparam logic [7:0] CH_AT = 8'h40;
   localparam logic [15:0] CD_KNOB_UP = 16'h5255;
   localparam logic [15:0] CD_KNOB_DN = 16'h5244;
   localparam logic [15:0] CD_TRIG_CFG = 16'h4354;
   localparam logic [15:0] CD_TRIG = 16'h5452;
   localparam logic [15:0] CD_SWP_OFF = 16'h5731;
   localparam logic [15:0] CD_SWP_AUTO = 16'h5732;
   localparam logic [15:0] CD_SWP_MAN = 16'h5733;
   localparam logic [15:0] CD_SWP_SGL = 16'h5734;
   localparam logic [15:0] CD_RSS_OFF = 16'h5930;
   localparam logic [15:0] CD_RSS_DISP = 16'h5931;
   localparam logic [15:0] CD_RSS_NODISP = 16'h5932;
   localparam logic [15:0] CD_SPECIAL = 16'h5350;
   localparam logic [15:0] CD_RD_MASK = 16'h524D;
   localparam logic [15:0] CD_RD_STATUS = 16'h4D53;
   localparam logic [15:0] CD_LEARN = 16'h4C31;
   localparam logic [15:0] CD_FAST_LEARN = 16'h4C32;
   localparam logic [15:0] CD_WR_MASK = 16'h4031;
   localparam logic [15:0] CD_DEFERRED = 16'h4032;
   localparam logic [15:0] CD_IMMEDIATE = 16'h4033;
   localparam logic [3:0] KNOB_LAST = 4'h9;
   localparam logic [15:0] SP_FINE_A = 16'h005E;
   localparam logic [15:0] SP_FINE_B = 16'h005F;
   // ------------------------------------------------------------
   // talk data kinds, register map, field positions, reset values
   // ------------------------------------------------------------
   localparam logic [1:0] TK_MASK = 2'h0;
   localparam logic [1:0] TK_STATUS = 2'h1;
   localparam logic [1:0] TK_LEARN = 2'h2;
   localparam logic [1:0] TK_FAST = 2'h3;
   localparam logic [7:0] REG_STATE = 8'h00;
   localparam logic [7:0] REG_MASK = 8'h04;
   localparam logic [7:0] REG_CODE = 8'h08;
   localparam logic [7:0] REG_NUM = 8'h0C;
   localparam int ST_REMOTE = 0;
   localparam int ST_LOCKOUT = 1;
   localparam int ST_TALK = 2;
   localparam int ST_LISTEN = 3;
   localparam int ST_DEFERRED = 4;
   localparam int ST_TRIG_CFG = 5;
   localparam int ST_MAN_SWP = 6;
   localparam int ST_FINE = 7;
   localparam int ST_RSS = 8;
   localparam int ST_POLL = 9;
   localparam int ST_ADDR = 16;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam int SB_RQS = 6;
   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic atn;
      logic eoi;
      logic [7:0] data;
   } grc_bus_msg_type;
   typedef struct packed {
      logic valid;
      logic eoi;
      logic [1:0] kind;
      logic [7:0] data;
   } grc_tx_type;
   typedef struct packed {
      logic valid;
      logic exec;
      logic [15:0] code;
      logic [15:0] num;
   } grc_code_type;
endpackage

// *** grc_remote_ctl.sv ***
`timescale 1ns/1ps
// Operation
// - talk only talker and remote, or talker in serial poll; four kinds
// - trigger acts only when response configured
// - addressed and universal clear act alike
// - remote needs enable plus listen address
// - remote lamp: remote and data seen
// - addressed lamp: talker or listener, any state
// - go-to-local returns local, lamp off
// - panel key returns local unless locked
// - lockout disables panel key
// - enable false returns local, clears lockout, keeps addressing
// - take-control command ignored
// - service request only through enabled mask
// - serial poll returns eight-bit status byte
// - parallel poll never answered
// - interface clear drops talker and listener
// - letters decoded without regard to case
// - knob steps after ten codes, exceptions
// - deferred and immediate execution modes
// - data taken only remote and listening
// - string ends on LF, bang, end, internal
// - characters outside accepted set dropped
// - power-on: local, immediate, unaddressed, defaults
module grc_remote_ctl (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire grc_pkg::grc_bus_msg_type bus_in,
   input wire logic ren_pin,
   input wire logic ifc_pin,
   input wire logic local_key_pin,
   input wire logic [4:0] addr_sw,
   input wire logic int_term,
   input wire logic [7:0] status_cond,
   input wire logic [7:0] learn_data,
   input wire logic learn_last,
   input wire logic tx_ready,
   output grc_pkg::grc_tx_type tx_out,
   output grc_pkg::grc_code_type code_out,
   output logic srq_out,
   output logic remote_led,
   output logic addressed_led,
   output logic dev_clear,
   output logic trigger,
   output logic knob_up_step,
   output logic knob_dn_step
);
   typedef enum logic {PS_IDLE, PS_PAIR} grc_parse_type;
   typedef enum logic [1:0] {PD_NONE, PD_SPECIAL, PD_MASK} grc_pend_type;

   // ------------------------------------------------------------
   // pin synchronisers and switch address capture
   // ------------------------------------------------------------
   logic [7:0] sy1_r, sy2_r;
   logic key_d_r;
   logic [1:0] ld_cnt_r;
   logic [4:0] my_addr_r;
   logic ren_s, ifc_s, key_s;

   // two flops per pin before any logic looks at it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sy1_r <= 8'h00;
         sy2_r <= 8'h00;
         key_d_r <= 1'b0;
      end else begin
         sy1_r <= {ren_pin, ifc_pin, local_key_pin, addr_sw};
         sy2_r <= sy1_r;
         key_d_r <= sy2_r[5];
      end
   end
   assign ren_s = sy2_r[7];
   assign ifc_s = sy2_r[6];
   assign key_s = sy2_r[5] & ~key_d_r;

   // bus address taken from switches once after reset release
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ld_cnt_r <= 2'h0;
         my_addr_r <= 5'h00;
      end else begin
         if (ld_cnt_r != 2'h3) ld_cnt_r <= ld_cnt_r + 2'h1;
         if (ld_cnt_r == 2'h2) my_addr_r <= sy2_r[4:0];
      end
   end

   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   logic cmd_c, rx_c, mla_c, mta_c, oth_ta_c, gtl_c, dclr_c, get_c;
   logic rem_r, llo_r, tlk_r, lsn_r, seen_r, spe_r;

   // pass control and parallel poll bytes match nothing here
   assign cmd_c = bus_in.valid & bus_in.atn;
   assign mla_c = cmd_c & (bus_in.data[7:5] == grc_pkg::GRP_LISTEN)
      & (bus_in.data[4:0] == my_addr_r);
   assign mta_c = cmd_c & (bus_in.data[7:5] == grc_pkg::GRP_TALK)
      & (bus_in.data[4:0] == my_addr_r);
   assign oth_ta_c = cmd_c & (bus_in.data[7:5] == grc_pkg::GRP_TALK) & ~mta_c;
   assign gtl_c = cmd_c & lsn_r & (bus_in.data == grc_pkg::CMD_GTL);
   assign dclr_c = cmd_c & ((bus_in.data == grc_pkg::CMD_DCL)
      | (lsn_r & (bus_in.data == grc_pkg::CMD_SDC)));
   assign get_c = cmd_c & lsn_r & (bus_in.data == grc_pkg::CMD_GET);
   assign rx_c = bus_in.valid & ~bus_in.atn & rem_r & lsn_r;

   // remote, lockout and data-seen state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rem_r <= 1'b0;
         llo_r <= 1'b0;
         seen_r <= 1'b0;
      end else begin
         if (!ren_s) begin
            rem_r <= 1'b0;
            llo_r <= 1'b0;
         end else begin
            if (mla_c) rem_r <= 1'b1;
            else if (gtl_c) rem_r <= 1'b0;
            else if (key_s && !llo_r) rem_r <= 1'b0;
            if (cmd_c && bus_in.data == grc_pkg::CMD_LLO) llo_r <= 1'b1;
         end
         if (!rem_r) seen_r <= 1'b0;
         else if (rx_c) seen_r <= 1'b1;
      end
   end

   // talker, listener and serial poll state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tlk_r <= 1'b0;
         lsn_r <= 1'b0;
         spe_r <= 1'b0;
      end else if (ifc_s) begin
         tlk_r <= 1'b0;
         lsn_r <= 1'b0;
         spe_r <= 1'b0;
      end else if (cmd_c) begin
         if (mla_c) begin
            lsn_r <= 1'b1;
            tlk_r <= 1'b0;
         end else if (mta_c) begin
            tlk_r <= 1'b1;
            lsn_r <= 1'b0;
         end else if (oth_ta_c || bus_in.data == grc_pkg::CMD_UNT) begin
            tlk_r <= 1'b0;
         end else if (bus_in.data == grc_pkg::CMD_UNL) begin
            lsn_r <= 1'b0;
         end
         if (bus_in.data == grc_pkg::CMD_SPE) spe_r <= 1'b1;
         else if (bus_in.data == grc_pkg::CMD_SPD) spe_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // program character parser
   // ------------------------------------------------------------
   grc_parse_type ps_r;
   grc_pend_type pend_r;
   logic [7:0] first_r, ch_c;
   logic [15:0] num_r, code_c, code_r;
   logic is_alpha_c, is_dig_c, is_lead_c, acc_c, term_c, emit_c;

   // case folding and the query alias
   always_comb begin
      ch_c = bus_in.data;
      if (ch_c >= 8'h61 && ch_c <= 8'h7A) ch_c = ch_c - 8'h20;
      if (ch_c == grc_pkg::CH_QUEST) ch_c = grc_pkg::CH_AT;
   end
   assign is_alpha_c = (ch_c >= 8'h41) && (ch_c <= 8'h5A);
   assign is_dig_c = (ch_c >= 8'h30) && (ch_c <= 8'h39);
   assign is_lead_c = is_alpha_c | (ch_c == grc_pkg::CH_AT)
      | (ch_c == grc_pkg::CH_PLUS) | (ch_c == grc_pkg::CH_MINUS);
   assign acc_c = is_lead_c | is_dig_c | (ch_c == grc_pkg::CH_DOT);

   // code emission and string end
   always_comb begin
      emit_c = 1'b0;
      code_c = {first_r, ch_c};
      term_c = int_term | (cmd_c & bus_in.eoi);
      if (rx_c) begin
         if (ch_c == grc_pkg::CH_LF || ch_c == grc_pkg::CH_EXCL || bus_in.eoi) begin
            term_c = 1'b1;
         end
         if (ps_r == PS_PAIR && acc_c) emit_c = 1'b1;
      end
   end

   // pairing and numeric field
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ps_r <= PS_IDLE;
         first_r <= 8'h00;
         num_r <= 16'h0000;
      end else if (dclr_c || emit_c || term_c) begin
         ps_r <= PS_IDLE;
         num_r <= 16'h0000;
      end else if (rx_c) begin
         case (ps_r)
            PS_IDLE: begin
               if (is_lead_c) begin
                  ps_r <= PS_PAIR;
                  first_r <= ch_c;
               end else if (is_dig_c) begin
                  num_r <= 16'(num_r * 16'd10 + {12'h000, ch_c[3:0]});
               end
            end
            default: ps_r <= PS_PAIR;
         endcase
      end
   end

   // ------------------------------------------------------------
   // code actions
   // ------------------------------------------------------------
   logic defer_r, trig_cfg_r, man_r, fine_r, rss_r, knob_dir_r;
   logic [3:0] knob_cnt_r;
   logic [7:0] mask_r;
   logic knob_c, wr_mask_c;

   assign knob_c = emit_c & (code_c == grc_pkg::CD_KNOB_UP | code_c == grc_pkg::CD_KNOB_DN);
   assign wr_mask_c = pready & pwrite & (paddr == grc_pkg::REG_MASK);

   // modes, trigger setup, sweep and service mask
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         defer_r <= 1'b0;
         trig_cfg_r <= 1'b0;
         rss_r <= 1'b0;
         man_r <= 1'b0;
         fine_r <= 1'b0;
         pend_r <= PD_NONE;
         mask_r <= grc_pkg::MASK_RST;
      end else begin
         if (wr_mask_c) mask_r <= pwdata[7:0];
         if (dclr_c) pend_r <= PD_NONE;
         else if (emit_c || term_c) begin
            if (pend_r == PD_SPECIAL && (num_r == grc_pkg::SP_FINE_A
                  || num_r == grc_pkg::SP_FINE_B)) fine_r <= 1'b1;
            if (pend_r == PD_MASK) mask_r <= num_r[7:0];
            pend_r <= PD_NONE;
         end
         if (emit_c) begin
            case (code_c)
               grc_pkg::CD_SPECIAL: pend_r <= PD_SPECIAL;
               grc_pkg::CD_WR_MASK: pend_r <= PD_MASK;
               grc_pkg::CD_DEFERRED: defer_r <= 1'b1;
               grc_pkg::CD_IMMEDIATE: defer_r <= 1'b0;
               grc_pkg::CD_TRIG_CFG: trig_cfg_r <= 1'b1;
               grc_pkg::CD_SWP_MAN: man_r <= 1'b1;
               grc_pkg::CD_SWP_OFF, grc_pkg::CD_SWP_AUTO,
               grc_pkg::CD_SWP_SGL: man_r <= 1'b0;
               grc_pkg::CD_RSS_DISP, grc_pkg::CD_RSS_NODISP: rss_r <= 1'b1;
               grc_pkg::CD_RSS_OFF: rss_r <= 1'b0;
               default: rss_r <= rss_r;
            endcase
         end
      end
   end

   // knob code counting and step pulses
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         knob_cnt_r <= 4'h0;
         knob_dir_r <= 1'b0;
         knob_up_step <= 1'b0;
         knob_dn_step <= 1'b0;
      end else begin
         knob_up_step <= 1'b0;
         knob_dn_step <= 1'b0;
         if (dclr_c || (emit_c && !knob_c)) knob_cnt_r <= 4'h0;
         else if (knob_c) begin
            knob_dir_r <= (code_c == grc_pkg::CD_KNOB_UP);
            if ((code_c == grc_pkg::CD_KNOB_UP) != knob_dir_r && !man_r && !fine_r) begin
               knob_cnt_r <= 4'h1;
            end else if (man_r || fine_r || knob_cnt_r == grc_pkg::KNOB_LAST) begin
               knob_cnt_r <= 4'h0;
               knob_up_step <= (code_c == grc_pkg::CD_KNOB_UP);
               knob_dn_step <= (code_c == grc_pkg::CD_KNOB_DN);
            end else begin
               knob_cnt_r <= knob_cnt_r + 4'h1;
            end
         end
      end
   end

   // code stream, trigger, clear and indicator outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         code_out <= '0;
         code_r <= 16'h0000;
         trigger <= 1'b0;
         dev_clear <= 1'b0;
         srq_out <= 1'b0;
         remote_led <= 1'b0;
         addressed_led <= 1'b0;
      end else begin
         code_out.valid <= emit_c;
         code_out.exec <= (emit_c && !defer_r) || (term_c && defer_r);
         if (emit_c) begin
            code_out.code <= code_c;
            code_out.num <= num_r;
            code_r <= code_c;
         end
         trigger <= trig_cfg_r && (get_c || (emit_c && code_c == grc_pkg::CD_TRIG));
         dev_clear <= dclr_c;
         srq_out <= |(status_cond & mask_r);
         remote_led <= rem_r & seen_r;
         addressed_led <= tlk_r | lsn_r;
      end
   end

   // ------------------------------------------------------------
   // talk data source
   // ------------------------------------------------------------
   logic tx_pend_r, tx_ok_c;
   logic [1:0] tx_kind_r;
   logic [7:0] sbyte_c;

   assign tx_ok_c = tlk_r & (rem_r | spe_r);
   assign sbyte_c = {status_cond[7], srq_out, status_cond[5:0]};

   // one byte at a time; learn kinds run until the last byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_pend_r <= 1'b0;
         tx_kind_r <= grc_pkg::TK_MASK;
         tx_out <= '0;
      end else begin
         if (emit_c && code_c == grc_pkg::CD_RD_MASK) begin
            tx_pend_r <= 1'b1;
            tx_kind_r <= grc_pkg::TK_MASK;
         end else if (emit_c && code_c == grc_pkg::CD_RD_STATUS) begin
            tx_pend_r <= 1'b1;
            tx_kind_r <= grc_pkg::TK_STATUS;
         end else if (emit_c && code_c == grc_pkg::CD_LEARN) begin
            tx_pend_r <= 1'b1;
            tx_kind_r <= grc_pkg::TK_LEARN;
         end else if (emit_c && code_c == grc_pkg::CD_FAST_LEARN) begin
            tx_pend_r <= 1'b1;
            tx_kind_r <= grc_pkg::TK_FAST;
         end else if (dclr_c || (tx_out.valid && tx_ready && tx_out.eoi && !spe_r)) begin
            tx_pend_r <= 1'b0;
         end
         if (!tx_ok_c || dclr_c || (tx_out.valid && tx_ready)) begin
            tx_out.valid <= 1'b0;
         end else if (!tx_out.valid && spe_r) begin
            tx_out <= {1'b1, 1'b1, grc_pkg::TK_STATUS, sbyte_c};
         end else if (!tx_out.valid && tx_pend_r && rem_r) begin
            tx_out.valid <= 1'b1;
            tx_out.kind <= tx_kind_r;
            case (tx_kind_r)
               grc_pkg::TK_MASK: tx_out.data <= mask_r;
               grc_pkg::TK_STATUS: tx_out.data <= status_cond;
               default: tx_out.data <= learn_data;
            endcase
            tx_out.eoi <= (tx_kind_r[1] == 1'b0) || learn_last;
         end
      end
   end

   // ------------------------------------------------------------
   // apb slave: one wait state, unmapped answers error
   // ------------------------------------------------------------
   logic [31:0] rd_c;
   logic hit_c;

   always_comb begin
      rd_c = 32'h0000_0000;
      hit_c = 1'b1;
      case (paddr)
         grc_pkg::REG_STATE: begin
            rd_c[grc_pkg::ST_REMOTE] = rem_r;
            rd_c[grc_pkg::ST_LOCKOUT] = llo_r;
            rd_c[grc_pkg::ST_TALK] = tlk_r;
            rd_c[grc_pkg::ST_LISTEN] = lsn_r;
            rd_c[grc_pkg::ST_DEFERRED] = defer_r;
            rd_c[grc_pkg::ST_TRIG_CFG] = trig_cfg_r;
            rd_c[grc_pkg::ST_MAN_SWP] = man_r;
            rd_c[grc_pkg::ST_FINE] = fine_r;
            rd_c[grc_pkg::ST_RSS] = rss_r;
            rd_c[grc_pkg::ST_POLL] = spe_r;
            rd_c[grc_pkg::ST_ADDR +: 5] = my_addr_r;
         end
         grc_pkg::REG_MASK: rd_c[7:0] = mask_r;
         grc_pkg::REG_CODE: rd_c[15:0] = code_r;
         grc_pkg::REG_NUM: rd_c[15:0] = num_r;
         default: hit_c = 1'b0;
      endcase
   end

   // answer in the cycle after the access phase opens
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~hit_c;
         prdata <= (psel & penable & ~pready & ~pwrite) ? rd_c : 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_local;
      !rem_r ##1 !remote_led;
   endsequence

   property p_tx_gate;
      $rose(tx_out.valid) |-> $past(tlk_r && (rem_r || spe_r));
   endproperty
   a_tx_gate: assert property (p_tx_gate) else $error("talk byte outside talk state");

   property p_trig_ignore;
      (get_c && !trig_cfg_r) |=> !trigger;
   endproperty
   a_trig_ignore: assert property (p_trig_ignore) else $error("unconfigured trigger acted");

   property p_clear;
      dclr_c |=> dev_clear;
   endproperty
   a_clear: assert property (p_clear) else $error("clear not signalled");

   property p_remote_in;
      (ren_s && mla_c) |=> rem_r;
   endproperty
   a_remote_in: assert property (p_remote_in) else $error("remote not entered");

   property p_led;
      remote_led |-> $past(rem_r && seen_r);
   endproperty
   a_led: assert property (p_led) else $error("remote lamp without data");

   property p_addr_led;
      (tlk_r || lsn_r) |=> addressed_led;
   endproperty
   a_addr_led: assert property (p_addr_led) else $error("addressed lamp off");

   property p_gtl;
      (ren_s && gtl_c) |=> s_local;
   endproperty
   a_gtl: assert property (p_gtl) else $error("go-to-local failed");

   property p_lockout;
      (llo_r && ren_s && rem_r && !gtl_c) |=> rem_r;
   endproperty
   a_lockout: assert property (p_lockout) else $error("locked remote dropped");

   property p_ren_off;
      !ren_s |=> s_local;
   endproperty
   a_ren_off: assert property (p_ren_off) else $error("enable false kept remote");

   property p_ifc;
      ifc_s |=> (!tlk_r && !lsn_r);
   endproperty
   a_ifc: assert property (p_ifc) else $error("interface clear ignored");

   property p_knob;
      knob_up_step |-> $past(man_r || fine_r || knob_cnt_r == grc_pkg::KNOB_LAST);
   endproperty
   a_knob: assert property (p_knob) else $error("knob step too early");

   property p_srq;
      srq_out |-> $past(|(status_cond & mask_r));
   endproperty
   a_srq: assert property (p_srq) else $error("service request not masked");
endmodule

// *** grc_ctl_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// bus controller model: drives bus bytes, ren and ifc levels
// ------------------------------------------------------------
module grc_ctl_model (
   input wire logic clk,
   output grc_pkg::grc_bus_msg_type bus_in,
   output logic ren_pin,
   output logic ifc_pin,
   output logic tx_ready
);
   initial begin
      bus_in = '0;
      ren_pin = 1'b0;
      ifc_pin = 1'b0;
   end
   // taker stalls every other cycle; starts ready after the first edge
   always @(posedge clk) tx_ready <= (tx_ready !== 1'b1);
   // one byte, valid for exactly one cycle, then a gap
   task send(input logic atn, input logic eoi, input logic [7:0] d);
      @(posedge clk);
      bus_in <= '{1'b1, atn, eoi, d};
      @(posedge clk);
      bus_in <= '0;
   endtask
   // enable is raised before any listen address is sent
   task lev(input logic r, input logic f);
      @(posedge clk);
      ren_pin <= r;
      ifc_pin <= f;
   endtask
endmodule

// *** gpib_remote_control_logic_tb.sv ***
`timescale 1ns/1ps
module gpib_remote_control_logic_tb;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, perr, tx_ready;
   logic srq_out, remote_led, addressed_led, dev_clear, trigger, kup, kdn, ren, ifc, key;
   logic [7:0] paddr, cond;
   logic [31:0] pwdata, prdata, rd, m;
   logic [15:0] lc;
   grc_pkg::grc_bus_msg_type bus_in;
   grc_pkg::grc_tx_type tx_out;
   grc_pkg::grc_code_type code_out;
   int error_cnt, checked, seed, n_trg, n_clr, n_kup, n_kdn, i;
   grc_remote_ctl i_dut (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bus_in(bus_in), .ren_pin(ren), .ifc_pin(ifc),
      .local_key_pin(key), .addr_sw(5'h05), .int_term(1'b0), .status_cond(cond),
      .learn_data(8'h00), .learn_last(1'b0), .tx_ready(tx_ready), .tx_out(tx_out),
      .code_out(code_out), .srq_out(srq_out), .remote_led(remote_led),
      .addressed_led(addressed_led), .dev_clear(dev_clear), .trigger(trigger),
      .knob_up_step(kup), .knob_dn_step(kdn));
   grc_ctl_model i_ctl (.clk(clk), .bus_in(bus_in), .ren_pin(ren), .ifc_pin(ifc),
      .tx_ready(tx_ready));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // count output pulses and keep the last decoded code
   always @(posedge clk) begin
      if (trigger === 1'b1) n_trg++;
      if (dev_clear === 1'b1) n_clr++;
      if (kup === 1'b1) n_kup++;
      if (kdn === 1'b1) n_kdn++;
      if (code_out.valid === 1'b1) lc <= code_out.code;
   end
   task end_of_test;
      if (error_cnt == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("MISMATCH %s exp %h got %h", nm, e, g);
         error_cnt++;
      end
   endtask
   // service request expected from condition bits and mask
   function automatic logic [31:0] srq_exp(input logic [7:0] c, input logic [7:0] k);
      return {31'h0, |(c & k)};
   endfunction
   // one apb transfer, waits for pready under a bound
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      bit to;
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      to = (pready !== 1'b1);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      if (to) begin
         $display("MISMATCH pready exp 1 got 0");
         error_cnt++;
         end_of_test;
      end
   endtask
   // two characters of a program code, data bytes
   task str(input logic [15:0] c);
      i_ctl.send(1'b0, 1'b0, c[15:8]);
      i_ctl.send(1'b0, 1'b0, c[7:0]);
   endtask
   initial begin
      {error_cnt, checked, n_trg, n_clr, n_kup, n_kdn} = '0;
      seed = 10683;
      {psel, penable, pwrite, paddr, pwdata, cond, lc, key} = '0;
      rst_n = 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      apb(1'b0, grc_pkg::REG_STATE, 32'h0);
      chk("state", 32'h0005_0000, rd);
      apb(1'b0, 8'hF0, 32'h0);
      chk("slverr", 32'h1, perr);
      m = $random(seed) & 32'hFF;
      apb(1'b1, grc_pkg::REG_MASK, m);
      cond <= 8'($random(seed));
      apb(1'b0, grc_pkg::REG_MASK, 32'h0);
      chk("mask", m, rd);
      chk("srq", srq_exp(cond, m[7:0]), srq_out);
      i_ctl.lev(1'b1, 1'b0);
      repeat (3) @(posedge clk);
      i_ctl.send(1'b1, 1'b0, 8'h25);
      repeat (2) @(posedge clk);
      chk("aled", 32'h1, addressed_led);
      chk("rled0", 32'h0, remote_led);
      str(16'h6672);
      repeat (3) @(posedge clk);
      chk("code", 32'h4652, lc);
      chk("rled1", 32'h1, remote_led);
      for (int k = 0; k < 9; k++) str(k[0] ? 16'h7275 : 16'h5255);
      repeat (3) @(posedge clk);
      chk("knob9", 32'h0, n_kup);
      str(16'h7275);
      repeat (3) @(posedge clk);
      chk("knob", 32'h1, n_kup);
      str(grc_pkg::CD_SWP_MAN);
      str(grc_pkg::CD_KNOB_UP);
      str(grc_pkg::CD_KNOB_DN);
      repeat (3) @(posedge clk);
      chk("knob_man", 32'h2, n_kup);
      chk("knob_dn", 32'h1, n_kdn);
      i_ctl.send(1'b1, 1'b0, grc_pkg::CMD_GET);
      str(grc_pkg::CD_TRIG_CFG);
      i_ctl.send(1'b1, 1'b0, grc_pkg::CMD_GET);
      i_ctl.send(1'b1, 1'b0, grc_pkg::CMD_SDC);
      i_ctl.send(1'b1, 1'b0, grc_pkg::CMD_DCL);
      repeat (3) @(posedge clk);
      chk("trig", 32'h1, n_trg);
      chk("clear", 32'h2, n_clr);
      str(grc_pkg::CD_RD_MASK);
      i_ctl.send(1'b1, 1'b0, 8'h45);
      for (i = 0; i < 40 && tx_out.valid !== 1'b1; i++) @(posedge clk);
      chk("tx", {20'h0, 2'h3, grc_pkg::TK_MASK, m[7:0]}, {20'h0, tx_out});
      if (tx_out.valid !== 1'b1) end_of_test;
      i_ctl.send(1'b1, 1'b0, 8'h25);
      i_ctl.send(1'b1, 1'b0, grc_pkg::CMD_GTL);
      repeat (3) @(posedge clk);
      apb(1'b0, grc_pkg::REG_STATE, 32'h0);
      chk("gtl", 32'h8, rd & 32'hF);
      i_ctl.send(1'b1, 1'b0, 8'h25);
      key <= 1'b1;
      repeat (4) @(posedge clk);
      key <= 1'b0;
      apb(1'b0, grc_pkg::REG_STATE, 32'h0);
      chk("key", 32'h0, rd & 32'h1);
      i_ctl.send(1'b1, 1'b0, 8'h25);
      i_ctl.send(1'b1, 1'b0, grc_pkg::CMD_LLO);
      key <= 1'b1;
      repeat (4) @(posedge clk);
      key <= 1'b0;
      apb(1'b0, grc_pkg::REG_STATE, 32'h0);
      chk("llo", 32'h3, rd & 32'h3);
      i_ctl.lev(1'b1, 1'b1);
      repeat (5) @(posedge clk);
      apb(1'b0, grc_pkg::REG_STATE, 32'h0);
      chk("ifc", 32'h0, rd & 32'hC);
      i_ctl.lev(1'b0, 1'b0);
      repeat (5) @(posedge clk);
      apb(1'b0, grc_pkg::REG_STATE, 32'h0);
      chk("ren", 32'h0, rd & 32'h3);
      end_of_test;
   end
endmodule
